// File: dv/ad_pin_mux_and_strap_decode_bench.sv
`timescale 1ns/100ps
`include "adpm_regs.svh"
module ad_pin_mux_and_strap_decode_bench;
    import adpm_pkg::*;
    logic sys_clk = 0, rst = 1, hsel = 0, hwrite = 0, w16 = 0;
    logic [31:0] haddr = 0, hwdata = 0;
    logic [1:0]  htrans = 0, boot_s = 0, ratio_s = 0;
    logic [15:0] ext_d = 0, ext_oe = 0;
    wire hreadyout, hresp, ale_o, rd_n_o, wr_n_o, core_run_o;
    wire [31:0] hrdata;
    wire [15:0] pin_o, pin_oe, mem_o, mem_oe, pins;
    adpm_boot_e boot_mode;
    int n_errors = 0, checks_done = 0;

    // Undriven pins float to their pull-ups
    assign pins = (pin_oe & pin_o) | (~pin_oe & mem_oe & mem_o)
                | (~pin_oe & ~mem_oe & ext_oe & ext_d) | (~pin_oe & ~mem_oe & ~ext_oe);
    always #12.5 sys_clk = ~sys_clk;

    adpm_top #(.LOCK_CYCLES(8)) u_adpm_top (.sys_clk(sys_clk), .rst(rst), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .addr_data_pins_i(pins), .addr_data_pins_o(pin_o), .addr_data_pins_oe(pin_oe),
        .ale_o(ale_o), .rd_n_o(rd_n_o), .wr_n_o(wr_n_o), .strobe_pad_oe(), .strap_pad_oe(),
        .strap_pad_pu(), .boot_select_straps(boot_s), .core_ratio_straps(ratio_s),
        .boot_mode_o(boot_mode), .core_run_o(core_run_o));
    adpm_latch_mem u_adpm_latch_mem (.sys_clk(sys_clk), .width16(w16), .ale(ale_o),
        .rd_n(rd_n_o), .wr_n(wr_n_o), .pins(pins), .mem_o(mem_o), .mem_oe(mem_oe));

    ////////////////////////////////////////////////////////////////////////////////
    task finish_test;
        $display("errors %0d checks %0d", n_errors, checks_done);
        if (n_errors == 0 && checks_done > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task tick(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    task settle;
        tick(2);
    endtask
    task automatic wait_rdy;
        int i;
        i = 0;
        do begin
            @(posedge sys_clk);
            i++;
        end while (hreadyout !== 1'b1 && i < 50);
        if (hreadyout !== 1'b1) begin
            n_errors++;
            $display("[ERR] %0t bus hang", $time);
            finish_test();
        end
    endtask
    task automatic ahb(input logic [7:0] a, input logic w, input logic [31:0] wd,
                       output logic [31:0] rd);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        hwrite <= w;
        htrans <= 2'b10;
        wait_rdy();
        htrans <= 2'b00;
        hwdata <= wd;
        wait_rdy();
        rd = hrdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] x;
        ahb(a, 1'b1, d, x);
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
        logic [31:0] x;
        ahb(a, 1'b0, 32'h0, x);
        chk(x & m, e, "register read");
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_straps;
        for (int b = 0; b < 4; b++) begin
            rst <= 1'b1;
            boot_s <= b[1:0];
            ratio_s <= (b == 3) ? 2'd0 : b[1:0];
            tick(12);
            rst <= 1'b0;
            tick(1);
            chk(core_run_o, 0, "run early");
            wr(`ADPM_PWRCLK_OFS, 32'h7);
            rdchk(`ADPM_PWRCLK_OFS, (b == 1) ? 16 : (b == 2) ? 8 : 3, '1);
            boot_s <= ~b[1:0];
            for (int i = 0; i < 40 && core_run_o !== 1'b1; i++) tick(1);
            chk(core_run_o, 1, "run");
            rdchk(`ADPM_STATUS_OFS, 32'h40 | (32'h1 << b), '1);
            chk(boot_mode, 32'h1 << b, "boot");
            wr(`ADPM_PWRCLK_OFS, 32'h5);
            rdchk(`ADPM_PWRCLK_OFS, 32'h5, '1);
        end
    endtask
    task t_flags;
        rdchk(`ADPM_SYSTEM_CONTROL_REG_OFS, `ADPM_SYSTEM_CONTROL_REG_RST, '1);
        wr(`ADPM_SYSTEM_CONTROL_REG_OFS, 32'h0010_0000);
        wr(`ADPM_FLAG_DIR_OFS, 32'h00ff);
        wr(`ADPM_FLAG_OUT_OFS, 32'h1234);
        settle();
        chk({pin_oe, pins}, 32'hff00_34ff, "flag drive");
        wr(`ADPM_FLAG_DIR_OFS, 32'h0);
        ext_oe <= 16'hffff;
        ext_d <= 16'hab5c;
        settle();
        rdchk(`ADPM_FLAG_IN_OFS, 32'h5cab, '1);
        ext_oe <= 16'h0;
        wr(`ADPM_FLAG_DIR_OFS, 32'hffff);
        wr(`ADPM_SYSTEM_CONTROL_REG_OFS, 32'h0);
        settle();
        chk(pin_oe, 0, "flag off");
        wr(8'h30, 32'hffff_ffff);
        rdchk(8'h30, 32'h0, '1);
    endtask
    task automatic t_port(input logic m16, input logic [31:0] sys, input logic [23:0] a,
                          input logic [15:0] d, input logic [15:0] ea, input logic [15:0] ed);
        w16 <= m16;
        wr(`ADPM_SYSTEM_CONTROL_REG_OFS, sys);
        wr(`ADPM_PADDR_OFS, {8'h0, a});
        wr(`ADPM_PWDATA_OFS, {16'h0, d});
        wr(`ADPM_STROBE_OFS, 32'h1);
        settle();
        chk({ale_o, rd_n_o, wr_n_o, pins}, {3'b111, ea}, "address phase");
        wr(`ADPM_STROBE_OFS, 32'h4);
        settle();
        chk({ale_o, rd_n_o, wr_n_o, pins}, {3'b010, ed}, "write phase");
        wr(`ADPM_STROBE_OFS, 32'h1);
        wr(`ADPM_STROBE_OFS, 32'h2);
        settle();
        chk({ale_o, rd_n_o}, 0, "read phase");
        wr(`ADPM_STROBE_OFS, 32'h0);
        rdchk(`ADPM_PRDATA_OFS, m16 ? d : d[7:0], m16 ? 32'hffff : 32'hff);
    endtask

    initial begin
        t_straps();
        t_flags();
        t_port(1'b0, 32'h1, 24'ha1b2c3, 16'h00d4, 16'ha1b2, 16'hc3d4);
        t_port(1'b1, 32'h0010_0003, 24'h005e6f, 16'h9a8b, 16'h5e6f, 16'h9a8b);
        finish_test();
    end
    initial begin
        tick(20000);
        n_errors++;
        $display("[ERR] %0t run timeout", $time);
        finish_test();
    end
endmodule

// File: dv/adpm_latch_mem.sv
`timescale 1ns/100ps
module adpm_latch_mem (
    input  wire logic        sys_clk, // Core clock
    input  wire logic        width16, // 16-bit port mode
    input  wire logic        ale,     // Latch strobe
    input  wire logic        rd_n,    // Read strobe, low
    input  wire logic        wr_n,    // Write strobe, low
    input  wire logic [15:0] pins,    // Resolved pin levels
    output logic      [15:0] mem_o,   // Read data drive
    output logic      [15:0] mem_oe   // Read data enable
);
    // Tagged store: a wrongly latched address misses instead of aliasing
    logic [15:0] lat_q;
    logic [15:0] mem   [0:15];
    logic [23:0] tag   [0:15];
    logic [15:0] vld_q = 16'h0000;
    wire  [23:0] key = width16 ? {8'h00, lat_q} : {lat_q, pins[15:8]};
    wire  [3:0]  idx = key[3:0];

    always @(posedge sys_clk) begin
        if (ale) lat_q <= pins;
        if (!ale && !wr_n) begin
            mem[idx] <= pins;
            tag[idx] <= key;
            vld_q[idx] <= 1'b1;
        end
    end
    // Unwritten place gives a pattern, never a stale word
    assign mem_o = (vld_q[idx] && tag[idx] == key) ? mem[idx] : 16'h5a5a;
    assign mem_oe = (!rd_n && !ale) ? (width16 ? 16'hffff : 16'h00ff) : 16'h0000;
endmodule

// File: dv/adpm_top_asserts.sv
`timescale 1ns/100ps
module adpm_top_asserts
    import adpm_pkg::*;
#(
    parameter int LOCK_CYCLES = 4096
) (
    input wire logic        sys_clk,            // Core clock
    input wire logic        rst,                // Async reset, high
    input wire logic        hreadyout,          // Slave ready
    input wire logic        hresp,              // Response
    input wire logic [15:0] addr_data_pins_oe,  // Pin enables
    input wire logic        ale_o,              // Latch strobe
    input wire logic        rd_n_o,             // Read strobe, low
    input wire logic        wr_n_o,             // Write strobe, low
    input wire logic [2:0]  strobe_pad_oe,      // Strobe pad enables
    input wire logic [3:0]  strap_pad_oe,       // Strap pad enables
    input wire logic [3:0]  strap_pad_pu,       // Strap pull-ups
    input wire logic [1:0]  boot_select_straps, // Boot straps
    input wire adpm_boot_e  boot_mode_o,        // Boot mode
    input wire logic        core_run_o          // Core running
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);

    // Edges since release, saturating just past the lock point
    int unsigned cnt_q;
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            cnt_q <= 0;
        end else if (cnt_q < LOCK_CYCLES + 2) begin
            cnt_q <= cnt_q + 1;
        end
    end

    sequence s_release;
        $past(rst) && !rst;
    endsequence
    sequence s_lock_done;
        cnt_q == LOCK_CYCLES + 1;
    endsequence

    chk_strobe_driven: assert property (strobe_pad_oe == 3'h7)
        else $error("strobe pad released");
    chk_strap_pads: assert property (strap_pad_oe == 4'h0 && strap_pad_pu == 4'h0)
        else $error("strap pad driven or pulled");
    chk_bus_okay: assert property (hreadyout && !hresp)
        else $error("bus not ready or not okay");
    chk_boot_decode: assert property (s_release |=> boot_mode_o == (4'h1 << boot_select_straps))
        else $error("boot mode decode wrong");
    chk_boot_hold: assert property (core_run_o |-> $stable(boot_mode_o))
        else $error("boot mode changed after capture");
    chk_run_rise: assert property (s_lock_done |-> $rose(core_run_o))
        else $error("core run late");
    chk_run_early: assert property ($rose(core_run_o) |-> s_lock_done)
        else $error("core run early");
    chk_run_stays: assert property (core_run_o |=> core_run_o)
        else $error("core run dropped");
    chk_ale_drive: assert property (ale_o |-> addr_data_pins_oe == 16'hffff)
        else $error("address phase not driven");
    chk_wr_drive: assert property (!wr_n_o |-> addr_data_pins_oe == 16'hffff)
        else $error("write phase not driven");
    chk_read_float: assert property (!rd_n_o && !ale_o |-> addr_data_pins_oe[7:0] == 8'h00)
        else $error("data byte driven during read");
endmodule

bind adpm_top adpm_top_asserts #(.LOCK_CYCLES(LOCK_CYCLES)) u_adpm_top_asserts (
    .sys_clk(sys_clk), .rst(rst), .hreadyout(hreadyout), .hresp(hresp),
    .addr_data_pins_oe(addr_data_pins_oe), .ale_o(ale_o), .rd_n_o(rd_n_o),
    .wr_n_o(wr_n_o), .strobe_pad_oe(strobe_pad_oe), .strap_pad_oe(strap_pad_oe),
    .strap_pad_pu(strap_pad_pu), .boot_select_straps(boot_select_straps),
    .boot_mode_o(boot_mode_o), .core_run_o(core_run_o));

// File: include/adpm_pkg.sv
package adpm_pkg;

    typedef enum logic [3:0] {
        ADPM_BOOT_SPI_SLAVE  = 4'b0001,
        ADPM_BOOT_SPI_MASTER = 4'b0010,
        ADPM_BOOT_PAR_EPROM  = 4'b0100,
        ADPM_BOOT_ROM_ONLY   = 4'b1000
    } adpm_boot_e;

    typedef enum logic [2:0] {
        ADPM_ST_SAMPLE = 3'b001,
        ADPM_ST_LOCK   = 3'b010,
        ADPM_ST_RUN    = 3'b100
    } adpm_state_e;

    typedef logic [4:0] adpm_ratio_t;

    // Pin/flag map is a byte swap, same both ways
    function automatic logic [15:0] adpm_swap(input logic [15:0] v);
        adpm_swap = {v[7:0], v[15:8]};
    endfunction

endpackage

// File: include/adpm_regs.svh
// Contract
// - Flag function only when the flag-enable bit is set and the port is off.
// - Pins 0-7 carry flags 8-15; pins 8-15 carry flags 0-7, ascending.
// - Boot strap 00 selects serial slave boot, 01 serial master boot.
// - Boot strap 10 selects parallel EPROM boot, 11 on-chip ROM boot.
// - Ratio strap 00/01/10 gives 3x/16x/8x; 11 is reserved, never applied. The code loads 3x for 11 and flags it in status.
// - 8-bit mode, strobe high: low byte A15-8, high byte A23-16.
// - 8-bit mode, strobe low: low byte D7-0, high byte A7-0.
// - 16-bit mode, strobe high: low byte A7-0, high byte A15-8.
// - 16-bit mode, strobe low: pins carry D15-0, low byte on pins 7-0.
// - Read, write and latch strobes are always driven, never floated.
// - Output-only pads always enabled; input-only pads: no drive, no pull-up.
// - Straps set start-up rate only; software may change it after reset.
// - Core waits 4096 input clocks after reset release before running.
`ifndef ADPM_REGS_SVH
`define ADPM_REGS_SVH

`define ADPM_SYSTEM_CONTROL_REG_OFS     8'h00
`define ADPM_PWRCLK_OFS     8'h04
`define ADPM_FLAG_OUT_OFS   8'h08
`define ADPM_FLAG_DIR_OFS   8'h0c
`define ADPM_FLAG_IN_OFS    8'h10
`define ADPM_STATUS_OFS     8'h14
`define ADPM_PADDR_OFS      8'h18
`define ADPM_PWDATA_OFS     8'h1c
`define ADPM_STROBE_OFS     8'h20
`define ADPM_PRDATA_OFS     8'h24

`define ADPM_SYS_PORT_EN    0
`define ADPM_SYS_WIDTH16    1
`define ADPM_SYS_FLAG_EN    20

`define ADPM_STB_ALE        0
`define ADPM_STB_RD         1
`define ADPM_STB_WR         2

`define ADPM_SYSTEM_CONTROL_REG_RST     32'h0000_0000
`define ADPM_LOCK_CYCLES    4096

`endif

// File: src/adpm_ad_mux.sv
`timescale 1ns/100ps
module adpm_ad_mux
    import adpm_pkg::*;
(
    input  wire logic        flag_en,    // Flag-enable control bit
    input  wire logic        port_en,    // Parallel port enabled
    input  wire logic        width16,    // 16-bit port mode
    input  wire logic        ale,        // Latch strobe level
    input  wire logic        wr,         // Write strobe active
    input  wire logic [23:0] addr,       // Port address
    input  wire logic [15:0] wdata,      // Port write data
    input  wire logic [15:0] flag_out,   // Flag output values
    input  wire logic [15:0] flag_dir,   // Flag drive enables
    output logic      [15:0] pin_o,      // Pin values
    output logic      [15:0] pin_oe      // Pin drive enables
);

    logic        flag_mode;
    logic [15:0] port_val;
    logic [15:0] port_oe;

    assign flag_mode = flag_en && !port_en;

    assign port_val = (!width16 &&  ale) ? addr[23:8] :
                      (!width16 && !ale) ? {addr[7:0], wdata[7:0]} :
                      ( width16 &&  ale) ? addr[15:0] :
                                           wdata;

    // Address bytes always driven; data bytes only on writes
    assign port_oe = !port_en                ? 16'h0000 :
                     ale                     ? 16'hffff :
                     (!width16 && !wr)       ? 16'hff00 :
                     wr                      ? 16'hffff : 16'h0000;

    assign pin_o  = flag_mode ? adpm_swap(flag_out) : port_val;
    assign pin_oe = flag_mode ? adpm_swap(flag_dir) : port_oe;

endmodule

// File: src/adpm_strap_decode.sv
`timescale 1ns/100ps
`include "adpm_regs.svh"
module adpm_strap_decode
    import adpm_pkg::*;
#(
    parameter int LOCK_CYCLES = `ADPM_LOCK_CYCLES
) (
    input  wire logic        sys_clk,            // Core clock
    input  wire logic        rst,                // Async reset, high
    input  wire logic [1:0]  boot_select_straps, // Boot source pins
    input  wire logic [1:0]  core_ratio_straps,  // Ratio pins
    output adpm_boot_e       boot_mode,          // Decoded boot source
    output adpm_ratio_t      core_ratio,         // Start-up multiplier
    output logic             ratio_reserved,     // Reserved ratio seen
    output logic             strap_load,         // Pulse once straps held
    output logic             core_run            // Lock wait done
);

    // Wait counter is 16 bits wide
    if (LOCK_CYCLES < 1 || LOCK_CYCLES > 65535) begin : g_lock_check
        $error("adpm_strap_decode: LOCK_CYCLES out of range");
    end

    adpm_state_e  state_q, state_d;
    logic [1:0]   boot_q;
    logic [1:0]   ratio_q;
    logic [15:0]  cnt_q;

    always_comb begin
        state_d = state_q;
        case (state_q)
            ADPM_ST_SAMPLE: state_d = ADPM_ST_LOCK;
            ADPM_ST_LOCK: begin
                if (cnt_q == 16'(LOCK_CYCLES - 1))
                    state_d = ADPM_ST_RUN;
            end
            ADPM_ST_RUN:    state_d = ADPM_ST_RUN;
            default:        state_d = ADPM_ST_SAMPLE;
        endcase
    end

    // Straps caught by a clocked edge after release, never by the reset itself
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state_q <= ADPM_ST_SAMPLE;
            boot_q  <= 2'h0;
            ratio_q <= 2'h0;
            cnt_q   <= 16'h0;
        end else begin
            state_q <= state_d;
            if (state_q == ADPM_ST_SAMPLE) begin
                boot_q  <= boot_select_straps;
                ratio_q <= core_ratio_straps;
            end
            if (state_q == ADPM_ST_LOCK)
                cnt_q <= cnt_q + 16'h1;
        end
    end

    // One edge after capture, so the decoded ratio already reflects the pins
    assign strap_load     = (state_q == ADPM_ST_LOCK) && (cnt_q == 16'h0);
    assign core_run       = (state_q == ADPM_ST_RUN);
    assign ratio_reserved = (ratio_q == 2'h3);

    assign boot_mode = (boot_q == 2'h0) ? ADPM_BOOT_SPI_SLAVE :
                       (boot_q == 2'h1) ? ADPM_BOOT_SPI_MASTER :
                       (boot_q == 2'h2) ? ADPM_BOOT_PAR_EPROM :
                                          ADPM_BOOT_ROM_ONLY;

    // Reserved code falls back to the slowest rate as a safe guess
    assign core_ratio = (ratio_q == 2'h1) ? 5'h10 :
                        (ratio_q == 2'h2) ? 5'h08 :
                                            5'h03;

endmodule

// File: src/adpm_top.sv
// The implementer's own choices: the register offsets and register access over AHB-Lite.
`timescale 1ns/100ps
`include "adpm_regs.svh"
module adpm_top
    import adpm_pkg::*;
#(
    parameter int LOCK_CYCLES = `ADPM_LOCK_CYCLES
) (
    input  wire logic        sys_clk,            // 40 MHz core clock
    input  wire logic        rst,                // Async reset, high
    input  wire logic        hsel,               // Slave select
    input  wire logic [31:0] haddr,              // Byte address
    input  wire logic [1:0]  htrans,             // Transfer type
    input  wire logic        hwrite,             // Write access
    input  wire logic [2:0]  hsize,              // Transfer size
    input  wire logic [31:0] hwdata,             // Write data
    input  wire logic        hready,             // Bus ready
    output logic             hreadyout,          // Slave ready
    output logic             hresp,              // Always OKAY
    output logic      [31:0] hrdata,             // Read data
    input  wire logic [15:0] addr_data_pins_i,   // Pin levels
    output logic      [15:0] addr_data_pins_o,   // Pin drive values
    output logic      [15:0] addr_data_pins_oe,  // Pin drive enables
    output logic             ale_o,              // Address latch strobe
    output logic             rd_n_o,             // Read strobe, low
    output logic             wr_n_o,             // Write strobe, low
    output logic      [2:0]  strobe_pad_oe,      // Strobe pad enables
    output logic      [3:0]  strap_pad_oe,       // Strap pad enables
    output logic      [3:0]  strap_pad_pu,       // Strap pad pull-ups
    input  wire logic [1:0]  boot_select_straps, // Boot source straps
    input  wire logic [1:0]  core_ratio_straps,  // Core ratio straps
    output adpm_boot_e       boot_mode_o,        // Decoded boot source
    output logic             core_run_o          // Core may execute
);

    ////////////////////////////////////////////////////////////////////////
    // Strap capture and lock wait

    adpm_ratio_t start_ratio;
    logic        ratio_reserved;
    logic        strap_load;
    logic        core_run;

    adpm_strap_decode #(
        .LOCK_CYCLES (LOCK_CYCLES)
    ) u_strap (
        .sys_clk            (sys_clk),
        .rst                (rst),
        .boot_select_straps (boot_select_straps),
        .core_ratio_straps  (core_ratio_straps),
        .boot_mode          (boot_mode_o),
        .core_ratio         (start_ratio),
        .ratio_reserved     (ratio_reserved),
        .strap_load         (strap_load),
        .core_run           (core_run)
    );

    assign core_run_o = core_run;

    ////////////////////////////////////////////////////////////////////////
    // Bus slave: zero wait states, read data registered at address phase

    logic        acc_ok;
    logic        wr_pend_q;
    logic [7:0]  wr_ofs_q;
    logic [31:0] rd_val;

    logic [31:0] system_control_reg_q;
    logic [7:0]  pwrclk_q;
    logic [15:0] flag_out_q;
    logic [15:0] flag_dir_q;
    logic [23:0] paddr_q;
    logic [15:0] pwdata_q;
    logic [2:0]  strobe_q;
    logic [15:0] prdata_q;
    logic [31:0] hrdata_q;

    assign acc_ok    = hsel && htrans[1] && hready;
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = hrdata_q;

    // Unmapped offsets read zero and ignore writes
    always_comb begin
        case (haddr[7:0])
            `ADPM_SYSTEM_CONTROL_REG_OFS:   rd_val = system_control_reg_q;
            `ADPM_PWRCLK_OFS:   rd_val = {24'h0, pwrclk_q};
            `ADPM_FLAG_OUT_OFS: rd_val = {16'h0, flag_out_q};
            `ADPM_FLAG_DIR_OFS: rd_val = {16'h0, flag_dir_q};
            `ADPM_FLAG_IN_OFS:  rd_val = {16'h0, adpm_swap(addr_data_pins_i)};
            `ADPM_STATUS_OFS:   rd_val = {24'h0, ratio_reserved, core_run, 2'h0,
                                          boot_mode_o};
            `ADPM_PADDR_OFS:    rd_val = {8'h0, paddr_q};
            `ADPM_PWDATA_OFS:   rd_val = {16'h0, pwdata_q};
            `ADPM_STROBE_OFS:   rd_val = {29'h0, strobe_q};
            `ADPM_PRDATA_OFS:   rd_val = {16'h0, prdata_q};
            default:            rd_val = 32'h0000_0000;
        endcase
        if (haddr[31:8] != 24'h0)
            rd_val = 32'h0000_0000;
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            wr_pend_q <= 1'b0;
            wr_ofs_q  <= 8'h00;
            hrdata_q  <= 32'h0000_0000;
        end else begin
            wr_pend_q <= acc_ok && hwrite && (haddr[31:8] == 24'h0);
            if (acc_ok) begin
                wr_ofs_q <= haddr[7:0];
            end
            if (acc_ok && !hwrite) begin
                hrdata_q <= rd_val;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Control registers

    logic wr_sys;
    logic wr_pclk;

    assign wr_sys  = wr_pend_q && (wr_ofs_q == `ADPM_SYSTEM_CONTROL_REG_OFS);
    // Rate changes only once the lock wait is over
    assign wr_pclk = wr_pend_q && (wr_ofs_q == `ADPM_PWRCLK_OFS) && core_run;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            system_control_reg_q   <= `ADPM_SYSTEM_CONTROL_REG_RST;
            pwrclk_q   <= 8'h00;
            flag_out_q <= 16'h0000;
            flag_dir_q <= 16'h0000;
            paddr_q    <= 24'h00_0000;
            pwdata_q   <= 16'h0000;
            strobe_q   <= 3'h0;
        end else begin
            if (wr_sys)
                system_control_reg_q <= hwdata & ((32'h1 << `ADPM_SYS_FLAG_EN) | 32'h3);
            if (strap_load)
                pwrclk_q <= {3'h0, start_ratio};
            else if (wr_pclk)
                pwrclk_q <= hwdata[7:0];
            if (wr_pend_q && wr_ofs_q == `ADPM_FLAG_OUT_OFS)
                flag_out_q <= hwdata[15:0];
            if (wr_pend_q && wr_ofs_q == `ADPM_FLAG_DIR_OFS)
                flag_dir_q <= hwdata[15:0];
            if (wr_pend_q && wr_ofs_q == `ADPM_PADDR_OFS)
                paddr_q <= hwdata[23:0];
            if (wr_pend_q && wr_ofs_q == `ADPM_PWDATA_OFS)
                pwdata_q <= hwdata[15:0];
            if (wr_pend_q && wr_ofs_q == `ADPM_STROBE_OFS)
                strobe_q <= hwdata[2:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin multiplexing, registered toward the pads

    logic        port_en;
    logic        width16;
    logic        flag_en;
    logic [15:0] mux_o;
    logic [15:0] mux_oe;
    logic [15:0] pin_o_q;
    logic [15:0] pin_oe_q;
    logic        ale_q;
    logic        rd_n_q;
    logic        wr_n_q;

    assign port_en = system_control_reg_q[`ADPM_SYS_PORT_EN];
    assign width16 = system_control_reg_q[`ADPM_SYS_WIDTH16];
    assign flag_en = system_control_reg_q[`ADPM_SYS_FLAG_EN];

    adpm_ad_mux u_mux (
        .flag_en  (flag_en),
        .port_en  (port_en),
        .width16  (width16),
        .ale      (strobe_q[`ADPM_STB_ALE]),
        .wr       (strobe_q[`ADPM_STB_WR]),
        .addr     (paddr_q),
        .wdata    (pwdata_q),
        .flag_out (flag_out_q),
        .flag_dir (flag_dir_q),
        .pin_o    (mux_o),
        .pin_oe   (mux_oe)
    );

    // Strobes share the pin register stage so the latch sees them aligned
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            pin_o_q  <= 16'h0000;
            pin_oe_q <= 16'h0000;
            ale_q    <= 1'b0;
            rd_n_q   <= 1'b1;
            wr_n_q   <= 1'b1;
            prdata_q <= 16'h0000;
        end else begin
            pin_o_q  <= mux_o;
            pin_oe_q <= mux_oe;
            ale_q    <= port_en && strobe_q[`ADPM_STB_ALE];
            rd_n_q   <= !(port_en && strobe_q[`ADPM_STB_RD]);
            wr_n_q   <= !(port_en && strobe_q[`ADPM_STB_WR]);
            if (!rd_n_q && !ale_q)
                prdata_q <= width16 ? addr_data_pins_i : {8'h00, addr_data_pins_i[7:0]};
        end
    end

    assign addr_data_pins_o  = pin_o_q;
    assign addr_data_pins_oe = pin_oe_q;
    assign ale_o             = ale_q;
    assign rd_n_o            = rd_n_q;
    assign wr_n_o            = wr_n_q;

    ////////////////////////////////////////////////////////////////////////
    // Pad control

    assign strobe_pad_oe = 3'h7;
    assign strap_pad_oe  = 4'h0;
    assign strap_pad_pu  = 4'h0;

endmodule
